// ### design/fcp_protect.sv
// Notes on behaviour
// - No bits programmed: flash programmable and verifiable.
// - Bit one blocks external table reads internally.
// - Level two up: external access pin latched.
// - Level two up: programming rejected.
// - Bits one and two: verify disabled too.
// - All three: external execution forbidden too.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "fcp_defines.svh"

module fcp_protect (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  nv_sec_bits,
	input  wire logic        external_access_pin,
	input  wire logic        table_read_req,
	input  wire logic        fetch_external,
	input  wire logic        target_internal,
	input  wire logic        prog_req,
	input  wire logic        verify_req,
	input  wire logic        ext_fetch_req,
	output logic             table_read_grant,
	output logic             prog_grant,
	output logic             verify_grant,
	output logic             ext_fetch_grant,
	output logic             ea_effective,
	output logic             sec_valid
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and sequencer.

	logic                  ea_s1_r, ea_s2_r;
	logic [2:0]            sec_r;
	logic                  ea_lat_r;
	fcp_pkg::fcp_state_t   state_r;
	fcp_pkg::fcp_level_t   level;
	fcp_pkg::fcp_restrict_t rst_q;
	logic                  acc_ok, apb_wr, apb_rd;

	// Two flops before anything reads the pin. They carry no reset so that the
	// pin has already crossed them when the sequencer latches it two edges after
	// release; with a reset the latch could only ever capture the reset value.
	always_ff @(posedge pclk) begin
		if (clk_en) begin
			ea_s1_r <= external_access_pin;
			ea_s2_r <= ea_s1_r;
		end
	end

	assign acc_ok = psel & penable;
	assign apb_wr = acc_ok & pwrite;
	assign apb_rd = acc_ok & ~pwrite;

	// Bits and the pin are captured once after reset release; nothing reloads
	// them afterwards, so the level cannot change while running.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= fcp_pkg::FCP_ST_IDLE;
			sec_r    <= `FCP_SEC_RESET;
			ea_lat_r <= 1'b0;
		end else if (clk_en) begin
			case (state_r)
				fcp_pkg::FCP_ST_IDLE: begin
					state_r <= fcp_pkg::FCP_ST_LOAD;
				end
				fcp_pkg::FCP_ST_LOAD: begin
					sec_r    <= nv_sec_bits;
					ea_lat_r <= ea_s2_r;
					state_r  <= fcp_pkg::FCP_ST_RUN;
				end
				default: begin
					state_r <= fcp_pkg::FCP_ST_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Level decode. Undefined patterns fall to the level that their unbroken run
	// of set low bits implies; any set bit above the lowest clear bit is ignored.

	always_comb begin
		if (!sec_r[0])
			level = fcp_pkg::FCP_LVL_NONE;
		else if (!sec_r[1])
			level = fcp_pkg::FCP_LVL_READ;
		else if (!sec_r[2])
			level = fcp_pkg::FCP_LVL_VERIF;
		else
			level = fcp_pkg::FCP_LVL_EXEC;
	end

	always_comb begin
		rst_q.block_table    = (level != fcp_pkg::FCP_LVL_NONE);
		rst_q.ea_latch       = (level != fcp_pkg::FCP_LVL_NONE);
		rst_q.block_prog     = (level != fcp_pkg::FCP_LVL_NONE);
		rst_q.block_verify   = (level == fcp_pkg::FCP_LVL_VERIF) ||
		                       (level == fcp_pkg::FCP_LVL_EXEC);
		rst_q.block_ext_exec = (level == fcp_pkg::FCP_LVL_EXEC);
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered grants; nothing is granted until the level is loaded.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_read_grant <= 1'b0;
			prog_grant       <= 1'b0;
			verify_grant     <= 1'b0;
			ext_fetch_grant  <= 1'b0;
			ea_effective     <= 1'b0;
			sec_valid        <= 1'b0;
		end else if (clk_en) begin
			sec_valid        <= (state_r == fcp_pkg::FCP_ST_RUN);
			table_read_grant <= (state_r == fcp_pkg::FCP_ST_RUN) & table_read_req &
			                    ~(rst_q.block_table & fetch_external & target_internal);
			prog_grant       <= (state_r == fcp_pkg::FCP_ST_RUN) & prog_req &
			                    ~rst_q.block_prog;
			verify_grant     <= (state_r == fcp_pkg::FCP_ST_RUN) & verify_req &
			                    ~rst_q.block_verify;
			ext_fetch_grant  <= (state_r == fcp_pkg::FCP_ST_RUN) & ext_fetch_req &
			                    ~rst_q.block_ext_exec;
			ea_effective     <= rst_q.ea_latch ? ea_lat_r : ea_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero-wait, unmapped addresses answer with pslverr.
	// Data and error are formed from the setup cycle, so they stand for exactly
	// the one access cycle in which pready is high.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel & ~penable & ~pwrite) begin
				if (paddr == `FCP_OFF_STATUS) begin
					prdata[`FCP_ST_LEVEL_MSB:`FCP_ST_LEVEL_LSB] <= level;
					prdata[`FCP_ST_EA_BIT]                      <= ea_lat_r;
					prdata[`FCP_ST_VALID_BIT]                   <= (state_r == fcp_pkg::FCP_ST_RUN);
					prdata[`FCP_ST_BITS_MSB:`FCP_ST_BITS_LSB]   <= sec_r;
				end else if (paddr != `FCP_OFF_CTRL) begin
					pslverr <= 1'b1;
				end
			end else if (psel & ~penable & pwrite) begin
				if (paddr != `FCP_OFF_CTRL)
					pslverr <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_prog_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && rst_q.block_prog |=> !prog_grant)
		else $error("programming granted while protected");
	chk_verify_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sec_r[1:0] == 2'h3 |=> !verify_grant)
		else $error("verify granted at level three");
	chk_exec_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sec_r == 3'h7 |=> !ext_fetch_grant)
		else $error("external execution granted at level four");
	chk_table_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sec_r[0] && fetch_external && target_internal |=> !table_read_grant)
		else $error("external table read of internal byte granted");
	chk_open_grant: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_r == fcp_pkg::FCP_ST_RUN && sec_r == 3'h0 && prog_req && verify_req
		|=> prog_grant && verify_grant)
		else $error("unprotected flash refused");
	chk_ea_held: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_r == fcp_pkg::FCP_ST_RUN && rst_q.ea_latch |=> ea_effective == $past(ea_lat_r))
		else $error("latched pin value not used");
	chk_level_stable: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == fcp_pkg::FCP_ST_RUN |=> $stable(sec_r) && $stable(ea_lat_r))
		else $error("protection level changed after load");
	chk_load_time: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == fcp_pkg::FCP_ST_IDLE && clk_en ##1 clk_en |=> state_r == fcp_pkg::FCP_ST_RUN)
		else $error("load sequence too slow");

	// Positive checks and one gate check: rights that a lower level keeps must still be granted,
	// otherwise an over-eager decode would pass every blocking check above; and no grant may precede the load.
	chk_verify_open: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_r == fcp_pkg::FCP_ST_RUN && sec_r == 3'h1 && verify_req |=> verify_grant)
		else $error("verify refused at level two");
	chk_exec_open: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_r == fcp_pkg::FCP_ST_RUN && sec_r == 3'h3 && ext_fetch_req |=> ext_fetch_grant)
		else $error("external execution refused at level three");
	chk_table_open: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_r == fcp_pkg::FCP_ST_RUN && table_read_req && !target_internal |=> table_read_grant)
		else $error("table read of external byte refused");
	chk_grant_gated: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_r != fcp_pkg::FCP_ST_RUN
		|=> !table_read_grant && !prog_grant && !verify_grant && !ext_fetch_grant)
		else $error("grant issued before level loaded");
	chk_ea_live: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !rst_q.ea_latch |=> ea_effective == $past(ea_s2_r))
		else $error("pin not passed through while unprotected");

	cov_level_open: cover property (@(posedge pclk) sec_valid && level == fcp_pkg::FCP_LVL_NONE);
	cov_level_read: cover property (@(posedge pclk) sec_valid && level == fcp_pkg::FCP_LVL_READ);
	cov_level_exec: cover property (@(posedge pclk) sec_valid && level == fcp_pkg::FCP_LVL_EXEC);
	cov_apb_read:   cover property (@(posedge pclk) apb_rd && pready);
	cov_apb_write:  cover property (@(posedge pclk) apb_wr && pready);

endmodule : fcp_protect

// ### design/fcp_defines.svh
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// Register byte offsets on the APB.
`define FCP_OFF_CTRL    12'h000
`define FCP_OFF_STATUS  12'h004

// Control register fields.
`define FCP_CTRL_LOAD_BIT 0

// Status register field positions.
`define FCP_ST_LEVEL_LSB  0
`define FCP_ST_LEVEL_MSB  1
`define FCP_ST_EA_BIT     2
`define FCP_ST_VALID_BIT  3
`define FCP_ST_BITS_LSB   4
`define FCP_ST_BITS_MSB   6

// Reset values.
`define FCP_SEC_RESET     3'h0

`endif

// ### design/fcp_pkg.sv
package fcp_pkg;

	// Decoded protection level; the usual path steps in Gray code.
	typedef enum logic [1:0] {
		FCP_LVL_NONE  = 2'h0,
		FCP_LVL_READ  = 2'h1,
		FCP_LVL_VERIF = 2'h3,
		FCP_LVL_EXEC  = 2'h2
	} fcp_level_t;

	// Sequencer for capturing security bits after reset.
	typedef enum logic [1:0] {
		FCP_ST_IDLE = 2'h0,
		FCP_ST_LOAD = 2'h1,
		FCP_ST_RUN  = 2'h3
	} fcp_state_t;

	// Restrictions derived from the level, travelling together.
	typedef struct packed {
		logic block_table;
		logic ea_latch;
		logic block_prog;
		logic block_verify;
		logic block_ext_exec;
	} fcp_restrict_t;

endpackage : fcp_pkg

// ### sim/fcp_far_side.sv
`timescale 1ns/100ps
// Far side: a parallel programmer that burns security bits, and code that raises requests.
module fcp_far_side (
	input  wire logic [1:0] sec_count,
	input  wire logic       pclk,
	input  wire logic [5:0] req,
	output logic      [2:0] nv_sec_bits,
	output logic            table_read_req,
	output logic            fetch_external,
	output logic            target_internal,
	output logic            prog_req,
	output logic            verify_req,
	output logic            ext_fetch_req
);
	// Only cumulative patterns are burned, since any other mix has no defined protection.
	always_ff @(posedge pclk) begin
		nv_sec_bits <= 3'h7 >> (2'h3 - sec_count);
	end
	// Requests launch on an edge and stand until the bench lowers them.
	always_ff @(posedge pclk) begin
		{table_read_req, fetch_external, target_internal, prog_req, verify_req, ext_fetch_req} <= req;
	end
endmodule : fcp_far_side

// ### sim/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, er, ce;
	logic        trq, fx, ti, prq, vrq, erq, tg, pg, vg, eg, ea, valid;
	logic [11:0] paddr;
	logic [31:0] prdata, rd;
	logic [1:0]  cnt;
	logic [5:0]  req;
	logic [2:0]  sec;
	int          failures, cmp_count;
	fcp_pkg::fcp_level_t lvl_map [4] = '{fcp_pkg::FCP_LVL_NONE, fcp_pkg::FCP_LVL_READ,
		fcp_pkg::FCP_LVL_VERIF, fcp_pkg::FCP_LVL_EXEC};
	fcp_far_side far (.pclk(pclk), .sec_count(cnt), .req(req), .nv_sec_bits(sec), .table_read_req(trq),
		.fetch_external(fx), .target_internal(ti), .prog_req(prq), .verify_req(vrq), .ext_fetch_req(erq));
	fcp_protect DUT (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(32'hffff_ffff), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nv_sec_bits(sec), .external_access_pin(pin), .table_read_req(trq),
		.fetch_external(fx), .target_internal(ti), .prog_req(prq), .verify_req(vrq),
		.ext_fetch_req(erq), .table_read_grant(tg), .prog_grant(pg), .verify_grant(vg),
		.ext_fetch_grant(eg), .ea_effective(ea), .sec_valid(valid));
	////////////////////////////////////////
	// Reset with a chosen level and pin, then wait for the bits to load; the watchdog bounds the wait.
	task automatic boot(input logic [1:0] c, input logic p);
		int n;
		presetn <= 1'b0;
		cnt <= c;
		pin <= p;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (valid !== 1'b1) begin @(posedge pclk); n++; end
		`CHK("load_cycles", 4, n)
	endtask : boot
	// One APB read; the request holds until pready is seen high at an edge.
	// A spare edge first keeps back-to-back calls from driving psel twice in one step.
	task automatic apb_rd(input logic [11:0] a);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= 1'b0;
		paddr <= a;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb_rd
	// One APB write of all ones; only the error answer is visible.
	task automatic apb_wr(input logic [11:0] a);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= a;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
	endtask : apb_wr
	// Every level: grants with all requests raised, status word, unmapped address.
	task automatic t_levels;
		for (int c = 0; c < 4; c++) begin
			boot(c[1:0], 1'b1);
			req <= 6'h3f;
			repeat (4) @(posedge pclk);
			`CHK("table_read_grant", c == 0, tg)
			`CHK("prog_grant", c == 0, pg)
			`CHK("verify_grant", c < 2, vg)
			`CHK("ext_fetch_grant", c < 3, eg)
			req <= 6'h37;
			repeat (4) @(posedge pclk);
			`CHK("table_read_grant", 1'b1, tg)
			req <= 6'h0;
			apb_rd(12'h004);
			`CHK("status", {3'(7 >> (3 - c)), 1'b1, lvl_map[c]}, {rd[6:3], rd[1:0]})
			`CHK("status_pin", 1'b1, rd[2])
			`CHK("pslverr", 1'b0, er)
			apb_rd(12'h008);
			`CHK("pslverr", 1'b1, er)
		end
	endtask : t_levels
	// The pin falls after reset; only level two and up keep the latched value.
	task automatic t_pin;
		for (int c = 0; c < 4; c += 2) begin
			boot(c[1:0], 1'b1);
			pin <= 1'b0;
			repeat (8) @(posedge pclk);
			`CHK("ea_effective", c[1], ea)
		end
	endtask : t_pin
	// Clearing the stored bits without a reset must not relax protection.
	task automatic t_hold;
		boot(2'h3, 1'b1);
		cnt <= 2'h0;
		req <= 6'h3f;
		repeat (6) @(posedge pclk);
		`CHK("prog_grant", 1'b0, pg)
		`CHK("ext_fetch_grant", 1'b0, eg)
		ce <= 1'b0;
		req <= 6'h37;
		repeat (4) @(posedge pclk);
		`CHK("table_read_grant", 1'b0, tg)
		ce <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("table_read_grant", 1'b1, tg)
		req <= 6'h0;
		apb_wr(12'h000);
		`CHK("pslverr", 1'b0, er)
		apb_wr(12'h004);
		`CHK("pslverr", 1'b1, er)
		apb_rd(12'h000);
		`CHK("ctrl", 32'h0000_0000, rd)
		apb_rd(12'h004);
		`CHK("level", fcp_pkg::FCP_LVL_EXEC, rd[1:0])
	endtask : t_hold
	task automatic summarize;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// Clock of 50 ns period.
	initial begin pclk = 1'b0; forever #25 pclk = ~pclk; end
	// Main sequence; a watchdog below cuts a hang short.
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
		cnt = 2'h0; req = 6'h0; pin = 1'b1; failures = 0; cmp_count = 0; ce = 1'b1;
		t_levels();
		t_pin();
		t_hold();
		summarize();
	end
	initial begin repeat (3000) @(posedge pclk); failures++; summarize(); end
endmodule : testbench
